// ---- rtl/synth_modem_config_regs.v ----
// Overview of operation
// - IF select is 5 bits, IF = f_xosc/1024 times it, reset value 15.
// - In receive the IF is taken off the base and drives the mixer.
// - The 8-bit signed offset, in f_xosc/16384 steps, adds to the base.
// - The top two bits of the 24-bit carrier word are read-only zero.
// - The base frequency is the 3-byte carrier word times f_xosc/65536.
// - Bandwidth fields set the decimation 8*(4+mantissa)*2^exponent.
// - The rate exponent is the low nibble of 0x10 and resets to 12.
// - The rate mantissa has a hidden leading one over a 4-bit exponent.
// - The data rate is (256+mantissa)*2^exponent/2^28 times f_xosc.
// - IF bit 5 is reserved storage, reset 0, written only as advised.
`timescale 1ns/1ps
`include "synth_modem_consts.vh"

module synth_modem_config_regs (
    input  wire                  mclk,
    input  wire                  rst_n,
    input  wire [`ADDR_W-1:0]    reg_addr,
    input  wire [7:0]            reg_wdata,
    input  wire                  reg_wr,
    input  wire                  reg_rd,
    input  wire                  rx_active,
    output reg  [7:0]            reg_rdata_q,
    output reg  [`SYNTH_W-1:0]   synth_carrier_word_word_q,
    output reg  [4:0]            mixer_if_sel_q,
    output reg                   if_reserved_q,
    output reg  [`DEC_W-1:0]     decimation_q,
    output reg  [1:0]            bandwidth_exponent_q,
    output reg  [1:0]            bandwidth_mantissa_q,
    output reg  [`RATE_W-1:0]    rate_step_q,
    output reg  [3:0]            symbol_rate_exponent_q
);

    // Index of an offset inside the bank
    function [2:0] reg_index;
        input [`ADDR_W-1:0] addr;
        reg   [`ADDR_W-1:0] diff;
        begin
            diff = addr - `REG_FIRST;
            reg_index = diff[2:0];
        end
    endfunction

    // Offset falls inside this bank
    function in_bank;
        input [`ADDR_W-1:0] addr;
        begin
            in_bank = (addr >= `OFF_IF_CARRIER_WORD_CTRL) &&
                      (addr <= `OFF_RATE_MANTISSA);
        end
    endfunction

    function [7:0] reset_of;
        input integer idx;
        begin
            case (idx)
                `IDX_IF_CARRIER_WORD_CTRL: reset_of = `RST_IF_CARRIER_WORD_CTRL;
                `IDX_SYNTH_OFFSET: reset_of = `RST_SYNTH_OFFSET;
                `IDX_CARRIER_HIGH: reset_of = `RST_CARRIER_HIGH;
                `IDX_CARRIER_MID:  reset_of = `RST_CARRIER_MID;
                `IDX_CARRIER_LOW:  reset_of = `RST_CARRIER_LOW;
                `IDX_BW_RATE_EXP:  reset_of = `RST_BW_RATE_EXP;
                default:           reset_of = `RST_RATE_MANTISSA;
            endcase
        end
    endfunction

    function [7:0] wmask_of;
        input integer idx;
        begin
            case (idx)
                `IDX_IF_CARRIER_WORD_CTRL: wmask_of = `WMASK_IF_CARRIER_WORD_CTRL;
                `IDX_SYNTH_OFFSET: wmask_of = `WMASK_FULL;
                `IDX_CARRIER_HIGH: wmask_of = `WMASK_CARRIER_HIGH;
                `IDX_CARRIER_MID:  wmask_of = `WMASK_FULL;
                `IDX_CARRIER_LOW:  wmask_of = `WMASK_FULL;
                `IDX_BW_RATE_EXP:  wmask_of = `WMASK_FULL;
                default:           wmask_of = `WMASK_FULL;
            endcase
        end
    endfunction

    wire [7:0]  reg_val [0:`REG_COUNT-1];
    wire [2:0]  wr_idx;
    wire        wr_hit;

    assign wr_idx = reg_index(reg_addr);
    assign wr_hit = reg_wr && in_bank(reg_addr);

    genvar gi;
    generate
        for (gi = 0; gi < `REG_COUNT; gi = gi + 1) begin : g_bank
            cfg_byte #(
                .RESET_VAL (reset_of(gi)),
                .WMASK     (wmask_of(gi))
            ) u_byte (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .wr_en   (wr_hit && (wr_idx == gi)),
                .wdata   (reg_wdata),
                .value_q (reg_val[gi])
            );
        end
    endgenerate

    wire [7:0] if_ctrl  = reg_val[`IDX_IF_CARRIER_WORD_CTRL];
    wire [7:0] offset   = reg_val[`IDX_SYNTH_OFFSET];
    wire [7:0] bw_rate  = reg_val[`IDX_BW_RATE_EXP];
    wire [7:0] rate_man = reg_val[`IDX_RATE_MANTISSA];

    wire [23:0] carrier_word = {reg_val[`IDX_CARRIER_HIGH],
                                reg_val[`IDX_CARRIER_MID],
                                reg_val[`IDX_CARRIER_LOW]};

    wire [4:0] intermediate_carrier_word_sel = if_ctrl[`IF_SEL_HI:`IF_SEL_LO];

    // offset scaled by four to the carrier step
    wire [`SYNTH_W-1:0] offset_term =
        {{(`SYNTH_W-8-`OFFSET_SHIFT){offset[7]}}, offset,
         {`OFFSET_SHIFT{1'b0}}};

    // IF scaled by 64 to the carrier step
    wire [`SYNTH_W-1:0] if_term =
        {{(`SYNTH_W-5-`IF_SHIFT){1'b0}}, intermediate_carrier_word_sel,
         {`IF_SHIFT{1'b0}}};

    reg  [`SYNTH_W-1:0] synth_carrier_word_word_d;
    always @* begin
        synth_carrier_word_word_d = {2'b00, carrier_word} + offset_term;
        if (rx_active) begin
            synth_carrier_word_word_d = synth_carrier_word_word_d - if_term;
        end
    end

    wire [1:0]        bw_e = bw_rate[`BW_EXP_HI:`BW_EXP_LO];
    wire [1:0]        bw_m = bw_rate[`BW_MANT_HI:`BW_MANT_LO];
    wire [2:0]        bw_sum = `BW_BASE + {1'b0, bw_m};
    wire [`DEC_W-1:0] decimation_d =
        {{(`DEC_W-3){1'b0}}, bw_sum} << (`BW_PRESCALE_SHIFT + bw_e);

    // hidden one then shift by exponent
    wire [3:0]         rate_e = bw_rate[`RATE_EXP_HI:`RATE_EXP_LO];
    wire [8:0]         rate_full = `MANT_HIDDEN_ONE | {1'b0, rate_man};
    wire [`RATE_W-1:0] rate_step_d =
        {{(`RATE_W-9){1'b0}}, rate_full} << rate_e;

    reg [7:0] reg_rdata_d;
    always @* begin
        reg_rdata_d = reg_rdata_q;
        if (reg_rd) begin
            if (in_bank(reg_addr)) begin
                reg_rdata_d = reg_val[wr_idx];
            end else begin
                reg_rdata_d = 8'h00;
            end
        end
    end

    // Read data holds until the next read strobe
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // Derived values are registered so consumers see a clean word
    // one cycle after a write instead of a ripple through the adder.
    // Carrier bytes land one at a time, so the word passes through
    // intermediate values; it wraps modulo 2^26.
    // synthesizer word
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            synth_carrier_word_word_q <= {`SYNTH_W{1'b0}};
        end else begin
            synth_carrier_word_word_q <= synth_carrier_word_word_d;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mixer_if_sel_q <= 5'h00;
            if_reserved_q  <= 1'b0;
        end else begin
            mixer_if_sel_q <= intermediate_carrier_word_sel;
            if_reserved_q  <= if_ctrl[`IF_RSVD_BIT];
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            decimation_q         <= {`DEC_W{1'b0}};
            bandwidth_exponent_q <= 2'h0;
            bandwidth_mantissa_q <= 2'h0;
        end else begin
            decimation_q         <= decimation_d;
            bandwidth_exponent_q <= bw_e;
            bandwidth_mantissa_q <= bw_m;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rate_step_q            <= {`RATE_W{1'b0}};
            symbol_rate_exponent_q <= 4'h0;
        end else begin
            rate_step_q            <= rate_step_d;
            symbol_rate_exponent_q <= rate_e;
        end
    end

endmodule

// ---- rtl/synth_modem_consts.vh ----
`ifndef SYNTH_MODEM_CONSTS_VH
`define SYNTH_MODEM_CONSTS_VH

// Register offsets on the register port
`define ADDR_W              6
`define OFF_IF_CARRIER_WORD_CTRL    6'h0b
`define OFF_SYNTH_OFFSET    6'h0c
`define OFF_CARRIER_HIGH    6'h0d
`define OFF_CARRIER_MID     6'h0e
`define OFF_CARRIER_LOW     6'h0f
`define OFF_BW_RATE_EXP     6'h10
`define OFF_RATE_MANTISSA   6'h11
`define REG_FIRST           6'h0b
`define REG_COUNT           7

// Register indices relative to the first offset
`define IDX_IF_CARRIER_WORD_CTRL    3'h0
`define IDX_SYNTH_OFFSET    3'h1
`define IDX_CARRIER_HIGH    3'h2
`define IDX_CARRIER_MID     3'h3
`define IDX_CARRIER_LOW     3'h4
`define IDX_BW_RATE_EXP     3'h5
`define IDX_RATE_MANTISSA   3'h6

// Reset values
`define RST_IF_CARRIER_WORD_CTRL    8'h0f
`define RST_SYNTH_OFFSET    8'h00
`define RST_CARRIER_HIGH    8'h1e
`define RST_CARRIER_MID     8'hc4
`define RST_CARRIER_LOW     8'hec
`define RST_BW_RATE_EXP     8'h8c
`define RST_RATE_MANTISSA   8'h22

// Writable bit masks; cleared bits are read-only zero
`define WMASK_IF_CARRIER_WORD_CTRL  8'h3f
`define WMASK_CARRIER_HIGH  8'h3f
`define WMASK_FULL          8'hff

// Field positions
`define IF_SEL_HI           4
`define IF_SEL_LO           0
`define IF_RSVD_BIT         5
`define BW_EXP_HI           7
`define BW_EXP_LO           6
`define BW_MANT_HI          5
`define BW_MANT_LO          4
`define RATE_EXP_HI         3
`define RATE_EXP_LO         0

// Arithmetic constants: widths, shifts to the f_xosc / 2^16 carrier step, rate and bandwidth terms
`define SYNTH_W             26
`define OFFSET_SHIFT        2
`define IF_SHIFT            6
`define MANT_HIDDEN_ONE     9'h100
`define BW_BASE             3'h4
`define BW_PRESCALE_SHIFT   3
`define DEC_W               9
`define RATE_W              24

`endif

// ---- rtl/cfg_byte.v ----
`timescale 1ns/1ps
// One configuration byte with a per-bit write mask.
module cfg_byte #(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] WMASK     = 8'hff
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       wr_en,
    input  wire [7:0] wdata,
    output reg  [7:0] value_q
);

    wire [7:0] value_d;

    // Masked bits never change and stay zero
    assign value_d = wr_en ? ((wdata & WMASK) | (value_q & ~WMASK))
                           : value_q;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= RESET_VAL & WMASK;
        end else begin
            value_q <= value_d;
        end
    end

endmodule

// ---- tb/synth_modem_config_regs_sva.sv ----
`timescale 1ns/1ps
module cfg_regs_checker (
    input wire        mclk,
    input wire        rst_n,
    input wire [5:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire        rx_active,
    input wire [7:0]  reg_rdata_q,
    input wire [25:0] synth_carrier_word_word_q,
    input wire [4:0]  mixer_if_sel_q,
    input wire        if_reserved_q,
    input wire [8:0]  decimation_q,
    input wire [1:0]  bandwidth_exponent_q,
    input wire [1:0]  bandwidth_mantissa_q,
    input wire [23:0] rate_step_q,
    input wire [3:0]  symbol_rate_exponent_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_quiet;
        !reg_wr [*3];
    endsequence
    sequence s_bw_steady;
        ($stable(bandwidth_exponent_q) && $stable(bandwidth_mantissa_q)) [*3];
    endsequence
    bw_decim_a: assert property (s_bw_steady |->
        decimation_q == ((9'd32 + 9'd8 * bandwidth_mantissa_q)
        << bandwidth_exponent_q)) else $error("decimation off");
    rate_form_a: assert property (
        $stable(symbol_rate_exponent_q) [*3] |->
        ((rate_step_q >> symbol_rate_exponent_q) inside {[24'd256:24'd511]})
        && ((rate_step_q & ~(24'hffffff << symbol_rate_exponent_q)) == 24'h0))
        else $error("rate step off");
    rx_mix_a: assert property (s_quiet ##1 $rose(rx_active) |=>
        synth_carrier_word_word_q == $past(synth_carrier_word_word_q)
        - {15'h0, mixer_if_sel_q, 6'h0}) else $error("if not subtracted");
    reset_vals_a: assert property ($rose(rst_n) |=>
        decimation_q == 9'd128 && symbol_rate_exponent_q == 4'hc
        && mixer_if_sel_q == 5'd15 && rate_step_q == 24'h122000)
        else $error("reset values off");
    unmapped_rd_a: assert property (
        reg_rd && (reg_addr < 6'h0b || reg_addr > 6'h11)
        |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
        else $error("read data moved");
    ro_bits_a: assert property (
        reg_rd && (reg_addr == 6'h0b || reg_addr == 6'h0d)
        |=> reg_rdata_q[7:6] == 2'b00) else $error("read-only bits set");
    if_read_a: assert property (
        s_quiet ##0 (reg_rd && reg_addr == 6'h0b) |=>
        reg_rdata_q[5:0] == {if_reserved_q, mixer_if_sel_q})
        else $error("if register readback differs");
endmodule

// ---- tb/reg_host.sv ----
`timescale 1ns/1ps
module reg_host (
    input  wire       mclk,
    input  wire [7:0] reg_rdata_q,
    output reg  [5:0] reg_addr,
    output reg  [7:0] reg_wdata,
    output reg        reg_wr,
    output reg        reg_rd
);
    initial begin
        reg_addr = 6'h3f;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Idle bus shows inverse, never stale data
    task wr(input [5:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge mclk);
            reg_wr <= 1'b0;
            reg_addr <= ~a;
            reg_wdata <= ~d;
        end
    endtask
    task rd(input [5:0] a, output [7:0] d);
        begin
            @(posedge mclk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            reg_addr <= ~a;
            #1;
            d = reg_rdata_q;
        end
    endtask
endmodule

// ---- tb/synth_modem_config_regs_bench.sv ----
`timescale 1ns/1ps
module synth_modem_config_regs_bench;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg         rx_active = 1'b0;
    wire [5:0]  reg_addr;
    wire [7:0]  reg_wdata;
    wire [7:0]  reg_rdata_q;
    wire        reg_wr;
    wire        reg_rd;
    wire [25:0] synth;
    wire [4:0]  if_sel;
    wire [8:0]  dec;
    wire [23:0] rate;
    wire [3:0]  r_exp;
    wire [1:0]  bw_e;
    wire [1:0]  bw_m;
    wire        rsv;
    reg  [7:0]  wd;
    reg  [7:0]  sh [0:6];
    reg  [7:0]  got;
    reg  [5:0]  a;
    integer     num_errors = 0;
    integer     checked = 0;
    integer     i;
    integer     k;
    always #50 mclk = ~mclk;
    synth_modem_config_regs dut (.mclk(mclk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .rx_active(rx_active), .reg_rdata_q(reg_rdata_q),
        .synth_carrier_word_word_q(synth), .mixer_if_sel_q(if_sel),
        .if_reserved_q(rsv), .decimation_q(dec), .bandwidth_exponent_q(bw_e),
        .bandwidth_mantissa_q(bw_m), .rate_step_q(rate),
        .symbol_rate_exponent_q(r_exp));
    reg_host host (.mclk(mclk), .reg_rdata_q(reg_rdata_q),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd));
    task chk(input [31:0] g, input [31:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    function [7:0] exp_rd(input [5:0] ad);
        exp_rd = (ad < 6'h0b || ad > 6'h11) ? 8'h00 : sh[ad - 6'h0b];
    endfunction
    function [25:0] exp_synth(input rx);
        exp_synth = {2'b00, sh[2], sh[3], sh[4]}
            + {{16{sh[1][7]}}, sh[1], 2'b00}
            - (rx ? {15'h0, sh[0][4:0], 6'h0} : 26'h0);
    endfunction
    task put(input [5:0] ad, input [7:0] d);
        begin
            host.wr(ad, d);
            if (ad >= 6'h0b && ad <= 6'h11)
                sh[ad - 6'h0b] = (ad == 6'h0b || ad == 6'h0d) ? d & 8'h3f : d;
        end
    endtask
    task verify;
        begin
            repeat (3) @(posedge mclk);
            #1;
            chk(synth, exp_synth(rx_active));
            chk(if_sel, sh[0][4:0]);
            chk(dec, (9'd32 + 9'd8 * sh[5][5:4]) << sh[5][7:6]);
            chk(rate, (32'd256 + sh[6]) << sh[5][3:0]);
            chk(r_exp, sh[5][3:0]);
            chk(bw_e, sh[5][7:6]);
            chk(bw_m, sh[5][5:4]);
            chk(rsv, sh[0][5]);
            for (k = 10; k < 19; k = k + 1) begin
                host.rd(6'(k), got);
                chk(got, exp_rd(6'(k)));
            end
        end
    endtask
    task complete_run;
        begin
            $display("errors %0d checks %0d", num_errors, checked);
            if (num_errors == 0 && checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #(100 * 4000);
        num_errors = num_errors + 1;
        complete_run;
    end
    initial begin
        sh[0] = 8'h0f;
        sh[1] = 8'h00;
        sh[2] = 8'h1e;
        sh[3] = 8'hc4;
        sh[4] = 8'hec;
        sh[5] = 8'h8c;
        sh[6] = 8'h22;
        i = $urandom(7674);
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        verify;
        put(6'h0b, 8'hff);
        put(6'h0d, 8'hff);
        put(6'h0c, 8'h80);
        put(6'h12, 8'h5a);
        verify;
        put(6'h0b, 8'h0f);
        for (i = 0; i < 60; i = i + 1) begin
            @(posedge mclk);
            rx_active <= 1'($urandom);
            a = (i % 4 == 0) ? 6'($urandom) : 6'(11 + $urandom % 7);
            wd = 8'($urandom) & ((a == 6'h0b) ? 8'hdf : 8'hff);
            put(a, wd);
            verify;
        end
        complete_run;
    end
endmodule
bind synth_modem_config_regs cfg_regs_checker u_checker (
    .mclk                   (mclk),
    .rst_n                  (rst_n),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .rx_active              (rx_active),
    .reg_rdata_q            (reg_rdata_q),
    .synth_carrier_word_word_q      (synth_carrier_word_word_q),
    .mixer_if_sel_q         (mixer_if_sel_q),
    .if_reserved_q          (if_reserved_q),
    .decimation_q           (decimation_q),
    .bandwidth_exponent_q   (bandwidth_exponent_q),
    .bandwidth_mantissa_q   (bandwidth_mantissa_q),
    .rate_step_q            (rate_step_q),
    .symbol_rate_exponent_q (symbol_rate_exponent_q)
);
